/* rtl/dlt_pkg.sv */
package dlt_pkg;

    localparam int DLT_MAIN_W = 16;
    localparam int DLT_CORR_W = 8;
    localparam int DLT_CLK_NS = 10;

    // Main latch timing
    localparam int DLT_MAIN_SETUP_NS = 140;
    localparam int DLT_MAIN_HOLD_NS = 120;
    localparam int DLT_MAIN_PULSE_NS = 250;
    // Correction latch timing
    localparam int DLT_SEL_SETUP_NS = 200;
    localparam int DLT_SEL_HOLD_NS = 20;
    localparam int DLT_CORR_SETUP_NS = 110;
    localparam int DLT_CORR_PULSE_NS = 100;

    // Least times round up
    localparam int DLT_MAIN_SETUP_CYC =
        (DLT_MAIN_SETUP_NS + DLT_CLK_NS - 1) / DLT_CLK_NS;
    localparam int DLT_MAIN_HOLD_CYC =
        (DLT_MAIN_HOLD_NS + DLT_CLK_NS - 1) / DLT_CLK_NS;
    localparam int DLT_MAIN_PULSE_CYC =
        (DLT_MAIN_PULSE_NS + DLT_CLK_NS - 1) / DLT_CLK_NS;
    localparam int DLT_SEL_SETUP_CYC =
        (DLT_SEL_SETUP_NS + DLT_CLK_NS - 1) / DLT_CLK_NS;
    localparam int DLT_SEL_HOLD_CYC =
        (DLT_SEL_HOLD_NS + DLT_CLK_NS - 1) / DLT_CLK_NS;
    localparam int DLT_CORR_SETUP_CYC =
        (DLT_CORR_SETUP_NS + DLT_CLK_NS - 1) / DLT_CLK_NS;
    localparam int DLT_CORR_PULSE_CYC =
        (DLT_CORR_PULSE_NS + DLT_CLK_NS - 1) / DLT_CLK_NS;

    localparam int DLT_CNT_W = 8;

    // Calibration codes
    localparam logic [15:0] DLT_CODE_UNI_ZERO = 16'h0000;
    localparam logic [15:0] DLT_CODE_BIP_ZERO = 16'h8000;
    localparam logic [15:0] DLT_CODE_FULL = 16'hffff;
    localparam logic [7:0] DLT_TRIM_START = 8'h80;

    // Pin levels; strobe idle and offset select are the reset values
    localparam logic DLT_STROBE_IDLE = 1'b1;
    localparam logic DLT_SEL_OFFSET = 1'b1;
    localparam logic DLT_SEL_GAIN = 1'b0;

    typedef enum logic [3:0] {
        DLT_IDLE = 4'h0,
        DLT_M_SET = 4'h1,
        DLT_M_LOW = 4'h3,
        DLT_M_HOLD = 4'h2,
        DLT_C_SEL = 4'h6,
        DLT_C_LOW = 4'h7,
        DLT_C_WAIT = 4'h5,
        DLT_C_HOLD = 4'h4,
        DLT_NORMAL = 4'hc
    } dlt_state_t;

    typedef enum logic [1:0] {
        DLT_PH_OFFSET = 2'h0,
        DLT_PH_GAIN = 2'h1,
        DLT_PH_WRITE = 2'h2
    } dlt_phase_t;

endpackage : dlt_pkg

/* rtl/dlt_pin_sync.sv */
`timescale 1ns/10ps
module dlt_pin_sync
    import dlt_pkg::*;
#(
    parameter int W = 2
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic [W-1:0] pin_in,
    output logic [W-1:0] level
);

    logic [W-1:0] s1_reg;
    logic [W-1:0] s2_reg;
    logic [W-1:0] s3_reg;
    logic [W-1:0] level_reg;
    wire [W-1:0] agree = ~(s2_reg ^ s3_reg);
    wire [W-1:0] level_next = (agree & s2_reg) | (~agree & level_reg);

    // Change accepted once stages two and three agree
    always_ff @(posedge clk) begin
        if (rst) begin
            s1_reg <= '0;
            s2_reg <= '0;
            s3_reg <= '0;
            level_reg <= '0;
        end else if (ce) begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            level_reg <= level_next;
        end
    end

    assign level = level_reg;

endmodule : dlt_pin_sync

/* rtl/dlt_ctrl.sv */
`timescale 1ns/10ps
module dlt_ctrl
    import dlt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cal_start,
    input wire logic bipolar,
    input wire logic cmp_high,
    input wire logic cmp_low,
    input wire logic wr_req,
    input wire logic [15:0] wr_data,
    output logic [15:0] main_data,
    output logic main_wr_n,
    output logic [7:0] corr_data,
    output logic corr_wr_n,
    output logic offset_sel,
    output logic busy,
    output logic cal_done,
    output logic [7:0] offset_code,
    output logic [7:0] gain_code
);

    dlt_state_t state_reg, state_next;
    dlt_phase_t phase_reg, phase_next;
    logic [DLT_CNT_W-1:0] cnt_reg, cnt_next;
    logic [15:0] main_data_reg, main_data_next;
    logic main_wr_n_reg, main_wr_n_next;
    logic [7:0] corr_data_reg, corr_data_next;
    logic corr_wr_n_reg, corr_wr_n_next;
    logic offset_sel_reg, offset_sel_next;
    logic busy_reg, busy_next;
    logic cal_done_reg, cal_done_next;
    logic [7:0] offset_code_reg, offset_code_next;
    logic [7:0] gain_code_reg, gain_code_next;
    logic [7:0] step_reg, step_next;
    logic [1:0] cmp_lvl;

    // Comparator from analog world is asynchronous
    dlt_pin_sync #(.W(2)) u_cmp_sync (
        .clk(clk),
        .rst(rst),
        .ce(ce),
        .pin_in({cmp_high, cmp_low}),
        .level(cmp_lvl)
    );

    // Strobe must satisfy both pulse width and data setup
    localparam int DLT_MAIN_LOW_CYC =
        (DLT_MAIN_PULSE_CYC > DLT_MAIN_SETUP_CYC) ? DLT_MAIN_PULSE_CYC
                                                  : DLT_MAIN_SETUP_CYC;

    function automatic logic [DLT_CNT_W-1:0] cyc(input int n);
        cyc = DLT_CNT_W'(n);
    endfunction : cyc

    wire cnt_done = (cnt_reg == '0);
    wire out_high = cmp_lvl[1];
    wire out_low = cmp_lvl[0];
    wire out_ok = ~out_high & ~out_low;
    wire step_last = (step_reg == 8'h00);
    // Unit step repeats once so code zero is reachable
    wire [7:0] step_amt = {1'b0, step_reg[7:1]} | {7'h00, step_reg[0]};
    // Larger code pulls output down, so high output means step up
    wire [7:0] trim_up = corr_data_reg + step_amt;
    wire [7:0] trim_dn = corr_data_reg - step_amt;
    wire [15:0] cal_zero = bipolar ? DLT_CODE_BIP_ZERO
                                   : DLT_CODE_UNI_ZERO;

    always_comb begin
        state_next = state_reg;
        phase_next = phase_reg;
        cnt_next = cnt_done ? cnt_reg : cnt_reg - 1'b1;
        main_data_next = main_data_reg;
        main_wr_n_next = main_wr_n_reg;
        corr_data_next = corr_data_reg;
        corr_wr_n_next = corr_wr_n_reg;
        offset_sel_next = offset_sel_reg;
        busy_next = busy_reg;
        cal_done_next = cal_done_reg;
        offset_code_next = offset_code_reg;
        gain_code_next = gain_code_reg;
        step_next = step_reg;
        case (state_reg)
            DLT_IDLE, DLT_NORMAL: begin
                if (cal_start) begin
                    busy_next = 1'b1;
                    cal_done_next = 1'b0;
                    phase_next = DLT_PH_OFFSET;
                    main_data_next = cal_zero;
                    main_wr_n_next = 1'b0;
                    cnt_next = cyc(DLT_MAIN_LOW_CYC);
                    state_next = DLT_M_LOW;
                end else if (wr_req) begin
                    busy_next = 1'b1;
                    phase_next = DLT_PH_WRITE;
                    main_data_next = wr_data;
                    main_wr_n_next = 1'b0;
                    cnt_next = cyc(DLT_MAIN_LOW_CYC);
                    state_next = DLT_M_LOW;
                end
            end
            DLT_M_LOW: begin
                // Strobe low long enough for pulse and setup
                if (cnt_done) begin
                    main_wr_n_next = 1'b1;
                    cnt_next = cyc(DLT_MAIN_HOLD_CYC);
                    state_next = DLT_M_HOLD;
                end
            end
            DLT_M_HOLD: begin
                if (cnt_done) begin
                    if (phase_reg == DLT_PH_WRITE) begin
                        busy_next = 1'b0;
                        state_next = cal_done_reg ? DLT_NORMAL : DLT_IDLE;
                    end else begin
                        offset_sel_next = (phase_reg == DLT_PH_OFFSET)
                            ? DLT_SEL_OFFSET : DLT_SEL_GAIN;
                        corr_data_next = DLT_TRIM_START;
                        step_next = 8'h80;
                        cnt_next = cyc(DLT_SEL_SETUP_CYC);
                        state_next = DLT_C_SEL;
                    end
                end
            end
            DLT_C_SEL: begin
                if (cnt_done) begin
                    corr_wr_n_next = 1'b0;
                    cnt_next = cyc(DLT_CORR_PULSE_CYC);
                    state_next = DLT_C_LOW;
                end
            end
            DLT_C_LOW: begin
                // Binary search on trim code while latch is open
                if (cnt_done) begin
                    if (out_ok || step_last) begin
                        cnt_next = cyc(DLT_CORR_SETUP_CYC);
                        state_next = DLT_C_WAIT;
                    end else begin
                        corr_data_next = out_high ? trim_up : trim_dn;
                        step_next = {1'b0, step_reg[7:1]};
                        cnt_next = cyc(DLT_CORR_PULSE_CYC);
                    end
                end
            end
            DLT_C_WAIT: begin
                if (cnt_done) begin
                    corr_wr_n_next = 1'b1;
                    cnt_next = cyc(DLT_SEL_HOLD_CYC);
                    state_next = DLT_C_HOLD;
                end
            end
            DLT_C_HOLD: begin
                // Select held past strobe rise
                if (cnt_done) begin
                    if (phase_reg == DLT_PH_OFFSET) begin
                        offset_code_next = corr_data_reg;
                        phase_next = DLT_PH_GAIN;
                        main_data_next = DLT_CODE_FULL;
                        main_wr_n_next = 1'b0;
                        cnt_next = cyc(DLT_MAIN_LOW_CYC);
                        state_next = DLT_M_LOW;
                    end else begin
                        gain_code_next = corr_data_reg;
                        main_wr_n_next = 1'b0;
                        busy_next = 1'b0;
                        cal_done_next = 1'b1;
                        state_next = DLT_NORMAL;
                    end
                end
            end
            default: begin
                state_next = DLT_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            state_reg <= DLT_IDLE;
            phase_reg <= DLT_PH_OFFSET;
            cnt_reg <= '0;
            main_data_reg <= '0;
            main_wr_n_reg <= DLT_STROBE_IDLE;
            corr_data_reg <= '0;
            corr_wr_n_reg <= DLT_STROBE_IDLE;
            offset_sel_reg <= DLT_SEL_OFFSET;
            busy_reg <= 1'b0;
            cal_done_reg <= 1'b0;
            offset_code_reg <= '0;
            gain_code_reg <= '0;
            step_reg <= '0;
        end else if (ce) begin
            state_reg <= state_next;
            phase_reg <= phase_next;
            cnt_reg <= cnt_next;
            main_data_reg <= main_data_next;
            main_wr_n_reg <= main_wr_n_next;
            corr_data_reg <= corr_data_next;
            corr_wr_n_reg <= corr_wr_n_next;
            offset_sel_reg <= offset_sel_next;
            busy_reg <= busy_next;
            cal_done_reg <= cal_done_next;
            offset_code_reg <= offset_code_next;
            gain_code_reg <= gain_code_next;
            step_reg <= step_next;
        end
    end

    assign main_data = main_data_reg;
    assign main_wr_n = main_wr_n_reg;
    assign corr_data = corr_data_reg;
    assign corr_wr_n = corr_wr_n_reg;
    assign offset_sel = offset_sel_reg;
    assign busy = busy_reg;
    assign cal_done = cal_done_reg;
    assign offset_code = offset_code_reg;
    assign gain_code = gain_code_reg;

endmodule : dlt_ctrl

/* tb/dlt_ctrl_chk.sv */
`timescale 1ns/10ps
module dlt_ctrl_chk
    import dlt_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic ce,
    input wire logic cal_start,
    input wire logic bipolar,
    input wire logic [15:0] main_data,
    input wire logic main_wr_n,
    input wire logic corr_wr_n,
    input wire logic offset_sel,
    input wire logic busy,
    input wire logic cal_done
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    cal_code_a: assert property (cal_start && ce && !busy |=>
        !main_wr_n && main_data == ($past(bipolar) ?
        DLT_CODE_BIP_ZERO : DLT_CODE_UNI_ZERO))
        else $error("wrong start code for calibration");
    main_setup_a: assert property ($rose(main_wr_n) |->
        $past(main_data, 25) == main_data && !$past(main_wr_n, 25))
        else $error("main word changed or strobe short before latch");
    main_hold_a: assert property ($rose(main_wr_n) |=>
        $stable(main_data) [*8])
        else $error("main word changed right after latch");
    sel_setup_a: assert property ($fell(corr_wr_n) |->
        $past(offset_sel, 20) == offset_sel)
        else $error("select not settled before trim strobe");
    sel_steady_a: assert property (!corr_wr_n
        && !$past(corr_wr_n) |-> $stable(offset_sel))
        else $error("select moved while trim strobe low");
    corr_width_a: assert property ($rose(corr_wr_n) |->
        !$past(corr_wr_n, 10))
        else $error("trim strobe pulse too short");
    sel_hold_a: assert property ($rose(corr_wr_n) |=>
        $stable(offset_sel) [*2])
        else $error("select moved right after trim latch");
    full_load_a: assert property ($rose(corr_wr_n)
        && offset_sel |-> ##[1:4] (!main_wr_n && main_data == DLT_CODE_FULL))
        else $error("full scale word not loaded after offset");
    resume_a: assert property ($rose(cal_done) |->
        !main_wr_n && !busy)
        else $error("main strobe not low at end of calibration");
endmodule : dlt_ctrl_chk

bind dlt_ctrl dlt_ctrl_chk dlt_ctrl_chk_inst (.clk(clk), .rst(rst), .ce(ce),
    .cal_start(cal_start), .bipolar(bipolar), .main_data(main_data),
    .main_wr_n(main_wr_n), .corr_wr_n(corr_wr_n), .offset_sel(offset_sel),
    .busy(busy), .cal_done(cal_done));

/* tb/dlt_dev_model.sv */
`timescale 1ns/10ps
module dlt_dev_model
    import dlt_pkg::*;
(
    input wire logic [15:0] main_data,
    input wire logic main_wr_n,
    input wire logic [7:0] corr_data,
    input wire logic corr_wr_n,
    input wire logic offset_sel,
    input wire logic [7:0] off_t,
    input wire logic [7:0] gain_t,
    output logic cmp_high,
    output logic cmp_low,
    output logic [15:0] main_q,
    output logic [7:0] off_q,
    output logic [7:0] gain_q
);
    logic [7:0] live_code;
    logic [7:0] tgt;
    always @* if (!main_wr_n) main_q = main_data;
    wire corr_open = !corr_wr_n;
    always @* if (corr_open && offset_sel) off_q = corr_data;
    always @* if (corr_open && !offset_sel) gain_q = corr_data;
    assign live_code = offset_sel ? off_q : gain_q;
    assign tgt = offset_sel ? off_t : gain_t;
    // Larger code pulls output down
    assign cmp_high = live_code < tgt;
    assign cmp_low = live_code > tgt;
endmodule : dlt_dev_model

/* tb/dlt_ctrl_tb.sv */
`timescale 1ns/10ps
module dlt_ctrl_tb;
    import dlt_pkg::*;
    logic clk = 0, rst = 1, ce = 1, cal_start = 0, bipolar = 0, wr_req = 0;
    logic [15:0] wr_data = 16'h0000, main_data, main_q;
    logic cmp_high, cmp_low, main_wr_n, corr_wr_n, offset_sel, busy, cal_done;
    logic [7:0] corr_data, offset_code, gain_code, off_q, gain_q;
    logic [7:0] off_t = 8'h00, gain_t = 8'h00;
    int bad_count = 0, checks_done = 0;
    always #5 clk = ~clk;
    dlt_ctrl dlt_ctrl_inst (.clk(clk), .rst(rst), .ce(ce),
        .cal_start(cal_start),
        .bipolar(bipolar), .cmp_high(cmp_high), .cmp_low(cmp_low),
        .wr_req(wr_req), .wr_data(wr_data), .main_data(main_data),
        .main_wr_n(main_wr_n), .corr_data(corr_data), .corr_wr_n(corr_wr_n),
        .offset_sel(offset_sel), .busy(busy), .cal_done(cal_done),
        .offset_code(offset_code), .gain_code(gain_code));
    dlt_dev_model dlt_dev_model_inst (.main_data(main_data),
        .main_wr_n(main_wr_n), .corr_data(corr_data), .corr_wr_n(corr_wr_n),
        .offset_sel(offset_sel), .off_t(off_t), .gain_t(gain_t),
        .cmp_high(cmp_high), .cmp_low(cmp_low), .main_q(main_q),
        .off_q(off_q), .gain_q(gain_q));

    task give_verdict;
        if (bad_count == 0 && checks_done > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : give_verdict
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp) begin
            bad_count++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task step(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : step
    function logic pick(input int w);
        case (w)
            0: return main_wr_n;
            1: return busy;
            default: return cal_done;
        endcase
    endfunction : pick
    task wait_for(input int w, input logic lvl);
        int i;
        for (i = 0; i < 3000 && pick(w) !== lvl; i++) step(1);
        if (i >= 3000) begin
            bad_count++;
            give_verdict();
        end
    endtask : wait_for
    task check_reset;
        chk(16'({main_wr_n, corr_wr_n, offset_sel}), 16'h0007);
        chk(16'({busy, cal_done}), 16'h0000);
        chk(main_data, 16'h0000);
    endtask : check_reset
    // Reset in the middle of a calibration
    task do_abort;
        cal_start = 1;
        step(1);
        cal_start = 0;
        step(60);
        chk(16'({offset_sel, busy}), 16'h0003);
        rst = 1;
        step(2);
        rst = 0;
        step(1);
        check_reset();
    endtask : do_abort
    // Write, then a second request while busy that must be ignored
    task do_write(input logic [15:0] d);
        wr_req = 1;
        wr_data = d;
        step(1);
        wr_req = 0;
        step(1);
        chk(16'({busy, main_wr_n}), 16'h0002);
        chk(main_data, d);
        wr_req = 1;
        wr_data = ~d;
        step(1);
        wr_req = 0;
        wait_for(1, 1'b0);
        chk(main_q, d);
    endtask : do_write
    // Calibration with write request raised alongside
    task do_cal(input logic bip, input logic [7:0] ot, input logic [7:0] gt);
        off_t = ot;
        gain_t = gt;
        bipolar = bip;
        cal_start = 1;
        wr_req = 1;
        wr_data = 16'h1234;
        step(1);
        cal_start = 0;
        wr_req = 0;
        wait_for(0, 1'b0);
        wait_for(0, 1'b1);
        chk(main_q, bip ? 16'h8000 : 16'h0000);
        wait_for(2, 1'b1);
        chk(16'(offset_code), 16'(ot));
        chk(16'(off_q), 16'(ot));
        chk(16'(gain_code), 16'(gt));
        chk(16'(gain_q), 16'(gt));
        chk(main_q, 16'hffff);
        chk(16'({main_wr_n, busy}), 16'h0000);
    endtask : do_cal

    initial begin
        step(16);
        rst = 0;
        step(1);
        check_reset();
        do_write(16'ha55a);
        do_cal(1'b0, 8'h5b, 8'ha4);
        do_cal(1'b1, 8'h01, 8'hff);
        do_write(16'h0001);
        do_abort();
        do_cal(1'b1, 8'h80, 8'h7f);
        give_verdict();
    end
endmodule : dlt_ctrl_tb
